// file: rtl/pfr_ctrl.sv
// power-fail restart sequencer with AHB-Lite register slave
// Behaviour
// - resistor overload select takes 0,1,2 on small drives, only 0 on large ones
// - restart mode accepts only values 0 to 5
// - mode 0: undervoltage trips at once, stops output, motor coasts
// - modes 0 and 2 never restart alone; need reset then run
// - mode 1: undervoltage stops output and coasts without fault
// - mode 1: fault raised at supply recovery; reset needed to resume
// - mode 2: undervoltage before motor stops raises fault and coasts
// - mode 3: regulate deceleration at continue level; undervoltage stops without fault
// - mode 3: recovery during ride-through accelerates back to original frequency
// - mode 3: after undervoltage restart from frequency latched at detection
// - mode 4: stop without fault; restart from frequency at power failure
// - mode 5: stop without fault; restart from starting frequency
// - pick-up selected: search coasting speed and resume matched to it
// - pick-up only for 5 to 120 Hz; otherwise regular restart
// - starting frequency configurable from 0.1 to 60 Hz
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`default_nettype none
`include "pfr_defs.svh"

module pfr_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // power stage
  input wire pfr_pkg::pfr_stage_in_t stageIn,
  input wire logic driveLarge,
  output var pfr_pkg::pfr_stage_out_t stageOut,
  output logic undervoltageFault,
  // interrupt
  output logic irq
);

  // ==========================================================================
  // declarations
  pfr_pkg::pfr_state_t state, next_state;
  pfr_pkg::pfr_stage_out_t next_stageOut;
  logic next_undervoltageFault;
  logic [15:0] latchedFreq, next_latchedFreq, origFreq, next_origFreq, restartFreq;
  logic [2:0] mode, next_mode;
  logic [1:0] resSel, next_resSel;
  logic pickup, next_pickup;
  logic [15:0] startFreq, next_startFreq, setFreq, next_setFreq;
  logic [2:0] irqStat, next_irqStat, irqMask, next_irqMask, events;
  logic [31:0] next_hrdata;
  logic dpWrite, next_dpWrite;
  logic [7:0] dpAddr, next_dpAddr;
  logic apSel, cmdReset, cmdRun, supplyOk, evFault, evUv, evRestart;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  function automatic logic wrHit(input logic wr, input logic [7:0] a, input logic [7:0] off);
    return wr && (a == off);
  endfunction : wrHit

  function automatic logic inPickupRange(input logic [15:0] f);
    return (f >= `PFR_PICKUP_MIN) && (f <= `PFR_PICKUP_MAX);
  endfunction : inPickupRange

  // ==========================================================================
  // bus decode
  assign apSel = hsel && htrans[1] && hready;
  assign cmdReset = wrHit(dpWrite, dpAddr, `PFR_OFF_CMD) && hwdata[`PFR_CMD_RESET_BIT];
  assign cmdRun = wrHit(dpWrite, dpAddr, `PFR_OFF_CMD) && hwdata[`PFR_CMD_RUN_BIT];
  assign supplyOk = !stageIn.underVolt && !stageIn.contLevel;
  assign events = {evRestart, evUv, evFault};

  pfr_restart_sel u_restartSel (
    .mclk(mclk),
    .resetn(resetn),
    .mode(mode),
    .latchedFreq(latchedFreq),
    .startFreq(startFreq),
    .restartFreq(restartFreq)
  );

  // ==========================================================================
  // register file
  always_comb
  begin
    next_dpWrite = apSel && hwrite;
    next_dpAddr = haddr[7:0];
    next_mode = mode;
    next_resSel = resSel;
    next_pickup = pickup;
    next_startFreq = startFreq;
    next_setFreq = setFreq;
    next_irqMask = irqMask;
    next_hrdata = 32'h0000_0000;
    if (wrHit(dpWrite, dpAddr, `PFR_OFF_CTRL))
    begin
      if (hwdata[`PFR_CTRL_MODE_LSB +: 3] <= `PFR_MODE_MAX)
      begin
        next_mode = hwdata[`PFR_CTRL_MODE_LSB +: 3];
      end
      if (hwdata[`PFR_CTRL_RES_LSB +: 2] <= `PFR_RES_MAX)
      begin
        next_resSel = hwdata[`PFR_CTRL_RES_LSB +: 2];
      end
      next_pickup = hwdata[`PFR_CTRL_PICKUP_BIT];
    end
    if (driveLarge)
    begin
      next_resSel = 2'h0;
    end
    if (wrHit(dpWrite, dpAddr, `PFR_OFF_START) && (hwdata[15:0] >= `PFR_START_MIN)
        && (hwdata[15:0] <= `PFR_START_MAX))
    begin
      next_startFreq = hwdata[15:0];
    end
    if (wrHit(dpWrite, dpAddr, `PFR_OFF_SETFREQ))
    begin
      next_setFreq = hwdata[15:0];
    end
    if (wrHit(dpWrite, dpAddr, `PFR_OFF_IRQ_MASK))
    begin
      next_irqMask = hwdata[2:0];
    end
    // read-to-clear; a new event in the same cycle still sets its bit
    next_irqStat = irqStat | events;
    if (apSel && !hwrite)
    begin
      unique case (haddr[7:0])
        `PFR_OFF_CTRL:
        begin
          next_hrdata[`PFR_CTRL_MODE_LSB +: 3] = mode;
          next_hrdata[`PFR_CTRL_RES_LSB +: 2] = resSel;
          next_hrdata[`PFR_CTRL_PICKUP_BIT] = pickup;
        end
        `PFR_OFF_START: next_hrdata[15:0] = startFreq;
        `PFR_OFF_STATUS:
        begin
          next_hrdata[2:0] = state;
          next_hrdata[`PFR_STAT_FAULT_BIT] = undervoltageFault;
          next_hrdata[`PFR_STAT_UV_BIT] = stageIn.underVolt;
          next_hrdata[`PFR_STAT_CONT_BIT] = stageIn.contLevel;
        end
        `PFR_OFF_IRQ_STAT:
        begin
          next_hrdata[2:0] = irqStat;
          next_irqStat = events;
        end
        `PFR_OFF_IRQ_MASK: next_hrdata[2:0] = irqMask;
        `PFR_OFF_SETFREQ: next_hrdata[15:0] = setFreq;
        `PFR_OFF_LATCH: next_hrdata[15:0] = latchedFreq;
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dpWrite <= 1'b0;
      dpAddr <= 8'h00;
      mode <= 3'h0;
      resSel <= 2'h0;
      pickup <= 1'b0;
      startFreq <= `PFR_RST_START_FREQ;
      setFreq <= `PFR_RST_SETFREQ;
      irqMask <= 3'h0;
      irqStat <= 3'h0;
      irq <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      dpWrite <= next_dpWrite;
      dpAddr <= next_dpAddr;
      mode <= next_mode;
      resSel <= next_resSel;
      pickup <= next_pickup;
      startFreq <= next_startFreq;
      setFreq <= next_setFreq;
      irqMask <= next_irqMask;
      irqStat <= next_irqStat;
      irq <= |(irqStat & irqMask);
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================================
  // power-fail sequencer
  always_comb
  begin
    next_state = state;
    next_stageOut = stageOut;
    next_stageOut.freqLoad = 1'b0;
    next_stageOut.searchStart = 1'b0;
    next_undervoltageFault = undervoltageFault;
    next_latchedFreq = latchedFreq;
    next_origFreq = origFreq;
    evFault = 1'b0;
    evUv = 1'b0;
    evRestart = 1'b0;
    unique case (state)
      pfr_pkg::ST_IDLE:
      begin
        if (cmdRun)
        begin
          next_state = pfr_pkg::ST_RUN;
          next_stageOut.outStop = 1'b0;
          next_stageOut.coast = 1'b0;
          next_stageOut.freqCmd = setFreq;
          next_stageOut.freqLoad = 1'b1;
          next_origFreq = setFreq;
        end
      end
      pfr_pkg::ST_RUN:
      begin
        if (stageIn.underVolt)
        begin
          evUv = 1'b1;
          next_latchedFreq = stageIn.outFreq;
          next_stageOut.outStop = 1'b1;
          next_stageOut.coast = 1'b1;
          if ((mode == pfr_pkg::MODE_TRIP_NOW) || (mode == pfr_pkg::MODE_DECEL_TRIP))
          begin
            next_undervoltageFault = 1'b1;
            evFault = 1'b1;
            next_state = pfr_pkg::ST_TRIP;
          end
          else
          begin
            next_state = pfr_pkg::ST_WAIT;
          end
        end
        else if (stageIn.contLevel && (mode == pfr_pkg::MODE_DECEL_TRIP))
        begin
          next_stageOut.decelCtrl = 1'b1;
          next_state = pfr_pkg::ST_DECEL;
        end
        else if (stageIn.contLevel && (mode == pfr_pkg::MODE_RIDE))
        begin
          next_stageOut.rideRegulate = 1'b1;
          next_state = pfr_pkg::ST_RIDE;
        end
      end
      pfr_pkg::ST_DECEL:
      begin
        if (stageIn.underVolt || stageIn.motorStopped)
        begin
          next_undervoltageFault = 1'b1;
          evFault = 1'b1;
          next_stageOut.decelCtrl = 1'b0;
          next_stageOut.outStop = 1'b1;
          next_stageOut.coast = stageIn.underVolt;
          next_state = pfr_pkg::ST_TRIP;
        end
      end
      pfr_pkg::ST_RIDE:
      begin
        if (stageIn.underVolt)
        begin
          evUv = 1'b1;
          next_latchedFreq = stageIn.outFreq;
          next_stageOut.rideRegulate = 1'b0;
          next_stageOut.outStop = 1'b1;
          next_stageOut.coast = 1'b1;
          next_state = pfr_pkg::ST_WAIT;
        end
        else if (!stageIn.contLevel)
        begin
          next_stageOut.rideRegulate = 1'b0;
          next_stageOut.freqCmd = origFreq;
          next_stageOut.freqLoad = 1'b1;
          evRestart = 1'b1;
          next_state = pfr_pkg::ST_RUN;
        end
      end
      pfr_pkg::ST_WAIT:
      begin
        if (supplyOk)
        begin
          if (mode == pfr_pkg::MODE_TRIP_RECOVER)
          begin
            next_undervoltageFault = 1'b1;
            evFault = 1'b1;
            next_state = pfr_pkg::ST_TRIP;
          end
          else if (pickup)
          begin
            next_stageOut.searchStart = 1'b1;
            next_state = pfr_pkg::ST_SEARCH;
          end
          else
          begin
            next_stageOut.outStop = 1'b0;
            next_stageOut.coast = 1'b0;
            next_stageOut.freqCmd = restartFreq;
            next_stageOut.freqLoad = 1'b1;
            evRestart = 1'b1;
            next_state = pfr_pkg::ST_RUN;
          end
        end
      end
      pfr_pkg::ST_SEARCH:
      begin
        if (stageIn.underVolt)
        begin
          next_state = pfr_pkg::ST_WAIT;
        end
        else if (stageIn.searchDone)
        begin
          next_stageOut.outStop = 1'b0;
          next_stageOut.coast = 1'b0;
          next_stageOut.freqCmd = inPickupRange(stageIn.searchFreq) ? stageIn.searchFreq
                                                                    : restartFreq;
          next_stageOut.freqLoad = 1'b1;
          evRestart = 1'b1;
          next_state = pfr_pkg::ST_RUN;
        end
      end
      pfr_pkg::ST_TRIP:
      begin
        if (cmdReset)
        begin
          next_undervoltageFault = 1'b0;
          next_state = pfr_pkg::ST_IDLE;
        end
      end
      default: next_state = pfr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= pfr_pkg::ST_IDLE;
      stageOut <= '{outStop: 1'b1, coast: 1'b0, decelCtrl: 1'b0, rideRegulate: 1'b0,
                    freqLoad: 1'b0, searchStart: 1'b0, freqCmd: 16'h0000};
      undervoltageFault <= 1'b0;
      latchedFreq <= 16'h0000;
      origFreq <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      stageOut <= next_stageOut;
      undervoltageFault <= next_undervoltageFault;
      latchedFreq <= next_latchedFreq;
      origFreq <= next_origFreq;
    end
  end

  // ==========================================================================
  // assertions

  property p_res_large;
    driveLarge |=> resSel == 2'h0;
  endproperty
  a_res_large: assert property (p_res_large) else $error("large drive resistor select not 0");

  property p_mode_range;
    mode <= `PFR_MODE_MAX;
  endproperty
  a_mode_range: assert property (p_mode_range) else $error("restart mode out of range");

  property p_mode0_trip;
    state == pfr_pkg::ST_RUN && mode == 3'h0 && stageIn.underVolt
      |=> undervoltageFault && stageOut.outStop && stageOut.coast;
  endproperty
  a_mode0_trip: assert property (p_mode0_trip) else $error("mode 0 did not trip");

  property p_trip_hold;
    state == pfr_pkg::ST_TRIP && !cmdReset |=> state == pfr_pkg::ST_TRIP && undervoltageFault;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("left trip without reset");

  property p_mode1_nofault;
    state == pfr_pkg::ST_RUN && mode == 3'h1 && stageIn.underVolt
      |=> !undervoltageFault && stageOut.outStop && state == pfr_pkg::ST_WAIT;
  endproperty
  a_mode1_nofault: assert property (p_mode1_nofault) else $error("mode 1 faulted early");

  property p_mode1_recover;
    state == pfr_pkg::ST_WAIT && mode == 3'h1 && supplyOk
      |=> undervoltageFault ##1 !stageOut.freqLoad;
  endproperty
  a_mode1_recover: assert property (p_mode1_recover) else $error("mode 1 no fault on recovery");

  property p_decel_fault;
    state == pfr_pkg::ST_DECEL && stageIn.underVolt |=> undervoltageFault && stageOut.coast;
  endproperty
  a_decel_fault: assert property (p_decel_fault) else $error("decel undervoltage not faulted");

  property p_ride_back;
    state == pfr_pkg::ST_RIDE && !stageIn.underVolt && !stageIn.contLevel
      |=> stageOut.freqLoad && stageOut.freqCmd == $past(origFreq) && !stageOut.outStop;
  endproperty
  a_ride_back: assert property (p_ride_back) else $error("ride-through recovery wrong");

  property p_pickup_range;
    state == pfr_pkg::ST_SEARCH && stageIn.searchDone && !stageIn.underVolt
      && !inPickupRange(stageIn.searchFreq) |=> stageOut.freqCmd == $past(restartFreq);
  endproperty
  a_pickup_range: assert property (p_pickup_range) else $error("pick-up range not honoured");

  property p_start_range;
    startFreq >= `PFR_START_MIN && startFreq <= `PFR_START_MAX;
  endproperty
  a_start_range: assert property (p_start_range) else $error("starting frequency out of range");

  c_mode3_ride: cover property (state == pfr_pkg::ST_RIDE ##[1:50] state == pfr_pkg::ST_RUN);
  c_mode5_restart: cover property (mode == 3'h5 && state == pfr_pkg::ST_WAIT ##1 stageOut.freqLoad);
  c_pickup: cover property (state == pfr_pkg::ST_SEARCH ##[1:50] state == pfr_pkg::ST_RUN);

endmodule : pfr_ctrl

`default_nettype wire

// file: rtl/pfr_defs.svh
// register offsets, field positions, reset values and limits of the power-fail restart block
`ifndef PFR_DEFS_SVH
`define PFR_DEFS_SVH

// ==========================================================================
// register offsets (byte addresses, one word each)
`define PFR_OFF_CTRL 8'h00
`define PFR_OFF_START 8'h04
`define PFR_OFF_STATUS 8'h08
`define PFR_OFF_IRQ_STAT 8'h0c
`define PFR_OFF_IRQ_MASK 8'h10
`define PFR_OFF_CMD 8'h14
`define PFR_OFF_SETFREQ 8'h18
`define PFR_OFF_LATCH 8'h1c

// ==========================================================================
// field positions
`define PFR_CTRL_MODE_LSB 0
`define PFR_CTRL_RES_LSB 4
`define PFR_CTRL_PICKUP_BIT 8
`define PFR_CMD_RESET_BIT 0
`define PFR_CMD_RUN_BIT 1
`define PFR_STAT_FAULT_BIT 3
`define PFR_STAT_UV_BIT 4
`define PFR_STAT_CONT_BIT 5
`define PFR_IRQ_FAULT_BIT 0
`define PFR_IRQ_UV_BIT 1
`define PFR_IRQ_RESTART_BIT 2

// ==========================================================================
// reset values and limits (frequencies in 0.1 Hz units)
`define PFR_RST_START_FREQ 16'h0005
`define PFR_RST_SETFREQ 16'h01f4
`define PFR_START_MIN 16'h0001
`define PFR_START_MAX 16'h0258
`define PFR_PICKUP_MIN 16'h0032
`define PFR_PICKUP_MAX 16'h04b0
`define PFR_MODE_MAX 3'h5
`define PFR_RES_MAX 2'h2

`endif

// file: rtl/pfr_pkg.sv
// types shared by the power-fail restart block
`default_nettype none

package pfr_pkg;

  // ==========================================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_DECEL = 3'b010,
    ST_RIDE = 3'b011,
    ST_WAIT = 3'b100,
    ST_SEARCH = 3'b101,
    ST_TRIP = 3'b110
  } pfr_state_t;

  // ==========================================================================
  // restart-after-power-failure modes
  typedef enum logic [2:0] {
    MODE_TRIP_NOW = 3'b000,
    MODE_TRIP_RECOVER = 3'b001,
    MODE_DECEL_TRIP = 3'b010,
    MODE_RIDE = 3'b011,
    MODE_RESTART_LAST = 3'b100,
    MODE_RESTART_START = 3'b101
  } pfr_mode_t;

  // ==========================================================================
  // power stage indications and commands
  typedef struct packed {
    logic underVolt;
    logic contLevel;
    logic motorStopped;
    logic searchDone;
    logic [15:0] searchFreq;
    logic [15:0] outFreq;
  } pfr_stage_in_t;

  typedef struct packed {
    logic outStop;
    logic coast;
    logic decelCtrl;
    logic rideRegulate;
    logic freqLoad;
    logic searchStart;
    logic [15:0] freqCmd;
  } pfr_stage_out_t;

endpackage : pfr_pkg

`default_nettype wire

// file: rtl/pfr_restart_sel.sv
// restart frequency selector: latched power-fail frequency or starting frequency
`default_nettype none

module pfr_restart_sel (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // selection inputs
  input wire logic [2:0] mode,
  input wire logic [15:0] latchedFreq,
  input wire logic [15:0] startFreq,
  // selected frequency
  output logic [15:0] restartFreq
);

  logic [15:0] next_restartFreq;

  always_comb
  begin
    if (mode == pfr_pkg::MODE_RESTART_START)
    begin
      next_restartFreq = startFreq;
    end
    else
    begin
      next_restartFreq = latchedFreq;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      restartFreq <= 16'h0000;
    end
    else
    begin
      restartFreq <= next_restartFreq;
    end
  end

endmodule : pfr_restart_sel

`default_nettype wire

// file: sim/pfr_stage_model.sv
// power stage and dc bus model facing the power-fail restart block
`default_nettype none

module pfr_stage_model (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // bench controls
  input wire logic [1:0] supply,
  input wire logic [15:0] motorFreq,
  input wire logic [7:0] stopLag,
  // block side
  input wire pfr_pkg::pfr_stage_out_t stageOut,
  output var pfr_pkg::pfr_stage_in_t stageIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] decelCnt;
  logic [3:0] searchCnt;
  logic searching;

  // ==========================================================================
  // registered indications; search answer only stands with its pulse
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stageIn <= '0;
      decelCnt <= 8'h00;
      searchCnt <= 4'h0;
      searching <= 1'b0;
    end
    else
    begin
      stageIn.underVolt <= (supply == 2'h2);
      stageIn.contLevel <= (supply != 2'h0);
      stageIn.outFreq <= motorFreq;
      decelCnt <= stageOut.decelCtrl ? decelCnt + 8'h01 : 8'h00;
      stageIn.motorStopped <= stageOut.decelCtrl && (decelCnt >= stopLag);
      searchCnt <= searching ? searchCnt + 4'h1 : 4'h0;
      if (stageOut.searchStart)
        searching <= 1'b1;
      else if (searchCnt == 4'h5)
        searching <= 1'b0;
      stageIn.searchDone <= searching && (searchCnt == 4'h5);
      stageIn.searchFreq <= (searching && searchCnt == 4'h5) ? motorFreq : ~stageIn.searchFreq;
    end
  end
endmodule : pfr_stage_model

`default_nettype wire

// file: sim/testbench.sv
// self-checking bench of the power-fail restart sequencer
`default_nettype none
`include "pfr_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic driveLarge = 1'b0;
  logic [1:0] supply = 2'h0;
  logic [15:0] motorFreq = 16'h01f4;
  logic [7:0] stopLag = 8'h1e;
  pfr_pkg::pfr_stage_in_t stageIn;
  pfr_pkg::pfr_stage_out_t stageOut;
  logic undervoltageFault;
  logic irq;
  logic [15:0] lastCmd = 16'h0;
  logic [15:0] loads = 16'h0;
  logic [15:0] loadMark = 16'h0;
  logic [31:0] rv;
  int err_total = 0;
  int comparisons = 0;

  always #12.5 mclk = ~mclk;
  always @(posedge mclk)
    if (stageOut.freqLoad === 1'b1)
    begin
      lastCmd <= stageOut.freqCmd;
      loads <= loads + 16'h1;
    end

  pfr_ctrl u_dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stageIn(stageIn),
    .driveLarge(driveLarge), .stageOut(stageOut), .undervoltageFault(undervoltageFault),
    .irq(irq));
  pfr_stage_model u_stage (.mclk(mclk), .resetn(resetn), .supply(supply),
    .motorFreq(motorFreq), .stopLag(stopLag), .stageOut(stageOut), .stageIn(stageIn));

  // ==========================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask : chk

  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1 && ++n < 50);
    rv = hrdata;
    if (n >= 50)
    begin
      err_total++;
      end_of_test();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rv & m, e);
  endtask : rchk

  task automatic st(input logic [3:0] e);
    rchk("status", `PFR_OFF_STATUS, 32'hf, {28'h0, e});
  endtask : st

  task automatic cmd(input logic [31:0] c);
    wr(`PFR_OFF_CMD, c);
    repeat (3) @(posedge mclk);
  endtask : cmd

  task automatic sup(input logic [1:0] v);
    supply <= v;
    repeat (5) @(posedge mclk);
  endtask : sup

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    chk("ready", {hreadyout, hresp, stageOut.outStop}, 3'h5);
    rchk("start", `PFR_OFF_START, 32'hffff, 32'h5);
    rchk("setfreq", `PFR_OFF_SETFREQ, 32'hffff, 32'h1f4);
    wr(`PFR_OFF_START, 32'h0);
    wr(`PFR_OFF_START, 32'h259);
    rchk("start", `PFR_OFF_START, 32'hffff, 32'h5);
    wr(`PFR_OFF_START, 32'h258);
    rchk("start", `PFR_OFF_START, 32'hffff, 32'h258);
    wr(`PFR_OFF_CTRL, 32'h025);
    wr(`PFR_OFF_CTRL, 32'h036);
    rchk("ctrl", `PFR_OFF_CTRL, 32'h1ff, 32'h025);
    driveLarge <= 1'b1;
    wr(`PFR_OFF_CTRL, 32'h014);
    rchk("ctrl", `PFR_OFF_CTRL, 32'h1ff, 32'h004);
    driveLarge <= 1'b0;
    wr(8'h20, 32'hffffffff);
    rchk("unmapped", 8'h20, 32'hffffffff, 32'h0);
  endtask : t_regs

  task automatic t_mode0();
    wr(`PFR_OFF_IRQ_MASK, 32'h7);
    wr(`PFR_OFF_CTRL, 32'h0);
    cmd(32'h2);
    bus(1'b0, `PFR_OFF_IRQ_STAT, 32'h0);
    sup(2'h2);
    chk("trip", {undervoltageFault, stageOut.outStop, stageOut.coast, irq}, 4'hf);
    st(4'he);
    rchk("irqstat", `PFR_OFF_IRQ_STAT, 32'h7, 32'h3);
    repeat (3) @(posedge mclk);
    chk("irq", irq, 1'b0);
    sup(2'h0);
    cmd(32'h2);
    st(4'he);
    cmd(32'h1);
    st(4'h0);
    cmd(32'h2);
    st(4'h1);
  endtask : t_mode0

  task automatic t_mode1();
    wr(`PFR_OFF_IRQ_MASK, 32'h0);
    wr(`PFR_OFF_CTRL, 32'h1);
    sup(2'h2);
    st(4'h4);
    rchk("status", `PFR_OFF_STATUS, 32'h3f, 32'h34);
    chk("wait", {undervoltageFault, stageOut.coast, irq}, 3'h2);
    sup(2'h0);
    st(4'he);
    chk("fault", undervoltageFault, 1'b1);
    cmd(32'h1);
    st(4'h0);
    cmd(32'h2);
  endtask : t_mode1

  task automatic t_mode2();
    wr(`PFR_OFF_CTRL, 32'h2);
    sup(2'h1);
    st(4'h2);
    chk("decel", {stageOut.decelCtrl, undervoltageFault}, 2'h2);
    repeat (40) @(posedge mclk);
    st(4'he);
    sup(2'h0);
    st(4'he);
    cmd(32'h1);
    cmd(32'h2);
    stopLag <= 8'hc8;
    sup(2'h1);
    sup(2'h2);
    chk("coast", {stageOut.coast, undervoltageFault}, 2'h3);
    st(4'he);
    stopLag <= 8'h1e;
    sup(2'h0);
    cmd(32'h1);
    cmd(32'h2);
  endtask : t_mode2

  task automatic t_mode3();
    wr(`PFR_OFF_CTRL, 32'h3);
    sup(2'h1);
    st(4'h3);
    chk("ride", stageOut.rideRegulate, 1'b1);
    loadMark = loads;
    sup(2'h0);
    st(4'h1);
    chk("freq", {loads - loadMark, lastCmd}, {16'h1, 16'h01f4});
    sup(2'h1);
    motorFreq <= 16'h0111;
    sup(2'h2);
    st(4'h4);
    loadMark = loads;
    sup(2'h0);
    st(4'h1);
    chk("freq", {loads - loadMark, lastCmd}, {16'h1, 16'h0111});
    rchk("latch", `PFR_OFF_LATCH, 32'hffff, 32'h111);
  endtask : t_mode3

  task automatic t_mode45();
    motorFreq <= 16'h0155;
    wr(`PFR_OFF_CTRL, 32'h4);
    sup(2'h2);
    st(4'h4);
    loadMark = loads;
    sup(2'h0);
    st(4'h1);
    chk("restart", {lastCmd, stageOut.outStop, stageOut.coast}, 18'h00554);
    chk("loads", loads - loadMark, 16'h1);
    wr(`PFR_OFF_CTRL, 32'h5);
    sup(2'h2);
    st(4'h4);
    loadMark = loads;
    sup(2'h0);
    chk("freq", {loads - loadMark, lastCmd}, {16'h1, 16'h0258});
  endtask : t_mode45

  task automatic t_pickup();
    logic [15:0] f [4];
    logic [15:0] e [4];
    f = '{16'h0032, 16'h04b0, 16'h0031, 16'h04b1};
    e = '{16'h0032, 16'h04b0, 16'h0258, 16'h0258};
    wr(`PFR_OFF_CTRL, 32'h105);
    for (int i = 0; i < 4; i++)
    begin
      motorFreq <= f[i];
      sup(2'h2);
      loadMark = loads;
      sup(2'h0);
      repeat (8) @(posedge mclk);
      chk("pickup", {loads - loadMark, lastCmd}, {16'h1, e[i]});
    end
  endtask : t_pickup

  initial
  begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_mode0();
    t_mode1();
    t_mode2();
    t_mode3();
    t_mode45();
    t_pickup();
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
